// ===== hw/nvm_irq_map.svh
`ifndef NVM_IRQ_MAP_SVH
`define NVM_IRQ_MAP_SVH

// Channel counts per device category
`define NVM_CHAN_CAT12 45
`define NVM_CHAN_CAT3 54
`define NVM_CHAN_CAT456 57
`define NVM_CORE_LINES 16
`define NVM_PRIO_BITS 4
// Exception numbers (vector index = address / 4)
`define NVM_EXC_RESET 6'h01
`define NVM_EXC_NMI 6'h02
`define NVM_EXC_HARD 6'h03
`define NVM_EXC_MEM 6'h04
`define NVM_EXC_BUS 6'h05
`define NVM_EXC_USAGE 6'h06
`define NVM_EXC_SVC 6'h0b
`define NVM_EXC_DBG 6'h0c
`define NVM_EXC_PSV 6'h0e
`define NVM_EXC_TICK 6'h0f
// Vector base of peripheral channels
`define NVM_CHAN_BASE 32'h0000_0040
// Peripheral channel positions
`define NVM_POS_PVD 1
`define NVM_POS_TAMPER 2
`define NVM_POS_RTCWK 3
`define NVM_POS_DMA_FIRST 11
`define NVM_POS_DMA_LAST 17
`define NVM_POS_USB_HIGH_PRIORITY_REQUEST 19
`define NVM_POS_USB_LOW_PRIORITY_REQUEST 20
`define NVM_POS_COMP 22
// Default priority offset of channel position
`define NVM_CHAN_PRIO_OFS 7
// System tick calibration: 1 ms at 4 MHz tick clock
`define NVM_TICK_PERIOD_US 1000
`define NVM_TICK_CLK_MHZ 4
`define NVM_TICK_CALIB (`NVM_TICK_PERIOD_US * `NVM_TICK_CLK_MHZ)
// Priority sentinels: fixed sources take negative values and rank above settable zero
`define NVM_PRIO_NONE 8'h7f
`define NVM_PRIO_RESET 8'hfd
`define NVM_PRIO_NMI 8'hfe
`define NVM_PRIO_HARD 8'hff

`endif

// ===== hw/nvm_irq_pkg.sv
package nvm_irq_pkg;
    // Device category selects channel count
    typedef enum logic [2:0] {
        NVM_CAT1 = 3'b000,
        NVM_CAT2 = 3'b001,
        NVM_CAT3 = 3'b010,
        NVM_CAT4 = 3'b011,
        NVM_CAT5 = 3'b100,
        NVM_CAT6 = 3'b101
    } nvm_cat_e;
    // Signed priority: fixed ones negative
    typedef logic signed [7:0] nvm_prio_t;
    typedef logic [5:0] nvm_excnum_t;
endpackage

// ===== hw/nvm_prio_cmp.sv
`timescale 1ns/1ps
`include "nvm_irq_map.svh"
// Two-way comparison stage: keeps the stronger candidate, lower index wins ties
module nvm_prio_cmp
    import nvm_irq_pkg::*;
#(
    parameter int IDXW = 7
) (
    // Candidate a
    input wire logic i_va,
    input wire nvm_prio_t i_pa,
    input wire logic [IDXW-1:0] i_ia,
    // Candidate b
    input wire logic i_vb,
    input wire nvm_prio_t i_pb,
    input wire logic [IDXW-1:0] i_ib,
    // Winner
    output logic o_v,
    output nvm_prio_t o_p,
    output logic [IDXW-1:0] o_i
);
    logic take_b;
    // Lower signed value is higher urgency; on equal values the lower index wins
    // The tree is not balanced, so index order cannot be left to wiring
    assign take_b = i_vb && (!i_va || (i_pb < i_pa) || ((i_pb == i_pa) && (i_ib < i_ia)));
    assign o_v = i_va || i_vb;
    assign o_p = take_b ? i_pb : i_pa;
    assign o_i = take_b ? i_ib : i_ia;
endmodule

// ===== hw/nvm_irq_ctrl.sv
`timescale 1ns/1ps
`include "nvm_irq_map.svh"
module nvm_irq_ctrl
    import nvm_irq_pkg::*;
#(
    parameter nvm_cat_e CATEGORY = NVM_CAT2,
    parameter int NCHAN = `NVM_CHAN_CAT456
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Core system exceptions
    input wire logic i_nmi_req,
    input wire logic i_clock_security_failure,
    input wire logic i_hard_fault_req,
    input wire logic i_memory_manage_fault_req,
    input wire logic i_bus_fault_req,
    input wire logic i_usage_fault_req,
    input wire logic i_supervisor_call_req,
    input wire logic i_debug_monitor_req,
    input wire logic i_pendable_service_req,
    input wire logic i_system_tick_timer,
    // Peripheral channel requests (level)
    input wire logic [NCHAN-1:0] i_chan_req,
    input wire logic i_supply_voltage_detector,
    input wire logic i_tamper_timestamp_request,
    input wire logic i_rtc_wakeup_request,
    input wire logic [6:0] i_dma_chan_req,
    input wire logic i_usb_high_priority_request,
    input wire logic i_usb_low_priority_request,
    input wire logic [1:0] i_comp_external_event_line,
    input wire logic i_touch_sense_request,
    // Channel enables and settable priorities
    input wire logic [NCHAN-1:0] i_chan_enable,
    input wire logic i_prio_override,
    input wire logic [NCHAN*`NVM_PRIO_BITS-1:0] i_chan_prio,
    input wire logic [7*`NVM_PRIO_BITS-1:0] i_sys_prio,
    // Core handshake
    input wire logic i_core_prio_valid,
    input wire nvm_prio_t i_core_prio,
    input wire logic i_entry_ack,
    input wire logic i_exit,
    // Presented exception to the core
    output logic o_exc_req,
    output nvm_excnum_t o_exc_num,
    output logic [8:0] o_exc_num_full,
    output logic [31:0] o_vector_addr,
    output nvm_prio_t o_exc_prio,
    output logic o_late_arrival,
    // Constant readback
    output logic [23:0] o_tick_calib,
    output logic [7:0] o_chan_count
);
    localparam int NSRC = 16 + NCHAN;
    localparam int IDXW = $clog2(NSRC);
    localparam int LVLS = NSRC;

    // Effective channel count by category
    logic [7:0] chan_count;
    always_comb begin
        case (CATEGORY)
            NVM_CAT1, NVM_CAT2: chan_count = 8'(`NVM_CHAN_CAT12);
            NVM_CAT3: chan_count = 8'(`NVM_CHAN_CAT3);
            NVM_CAT4, NVM_CAT5, NVM_CAT6: chan_count = 8'(`NVM_CHAN_CAT456);
            default: chan_count = 8'(`NVM_CHAN_CAT12);
        endcase
    end

    // Named peripheral sources merged into their channel slots; touch sense only when CATEGORY is NVM_CAT2
    logic [NCHAN-1:0] chan_raw;
    logic touch_present;
    assign touch_present = (CATEGORY == NVM_CAT2);
    always_comb begin
        chan_raw = i_chan_req;
        chan_raw[`NVM_POS_PVD] = i_chan_req[`NVM_POS_PVD] | i_supply_voltage_detector;
        chan_raw[`NVM_POS_TAMPER] = i_chan_req[`NVM_POS_TAMPER]
            | i_tamper_timestamp_request;
        chan_raw[`NVM_POS_RTCWK] = i_chan_req[`NVM_POS_RTCWK] | i_rtc_wakeup_request;
        for (int d = 0; d < 7; d++) begin
            chan_raw[`NVM_POS_DMA_FIRST + d] = i_chan_req[`NVM_POS_DMA_FIRST + d]
                | i_dma_chan_req[d];
        end
        chan_raw[`NVM_POS_USB_HIGH_PRIORITY_REQUEST] = i_chan_req[`NVM_POS_USB_HIGH_PRIORITY_REQUEST]
            | i_usb_high_priority_request;
        chan_raw[`NVM_POS_USB_LOW_PRIORITY_REQUEST] = i_chan_req[`NVM_POS_USB_LOW_PRIORITY_REQUEST]
            | i_usb_low_priority_request;
        chan_raw[`NVM_POS_COMP] = i_chan_req[`NVM_POS_COMP] | (|i_comp_external_event_line)
            | (touch_present & i_touch_sense_request);
    end

    // Source request, priority and index per exception number
    logic [NSRC-1:0] src_req;
    nvm_prio_t src_prio [NSRC];
    nvm_prio_t sys_prio [7];

    // Settable system exception ranks: defaults 0..6 or override fields
    always_comb begin
        for (int s = 0; s < 7; s++) begin
            sys_prio[s] = i_prio_override
                ? nvm_prio_t'({4'h0, i_sys_prio[s*`NVM_PRIO_BITS +: `NVM_PRIO_BITS]})
                : nvm_prio_t'(s);
        end
    end

    // Fixed and settable sources placed at their exception numbers
    always_comb begin
        src_req = '0;
        for (int k = 0; k < NSRC; k++) begin
            src_prio[k] = nvm_prio_t'(`NVM_PRIO_NONE);
        end
        // Reset vector is never requested here; slot 0 and gaps stay empty
        src_prio[`NVM_EXC_RESET] = nvm_prio_t'(`NVM_PRIO_RESET);
        src_req[`NVM_EXC_NMI] = i_nmi_req | i_clock_security_failure;
        src_prio[`NVM_EXC_NMI] = nvm_prio_t'(`NVM_PRIO_NMI);
        src_req[`NVM_EXC_HARD] = i_hard_fault_req;
        src_prio[`NVM_EXC_HARD] = nvm_prio_t'(`NVM_PRIO_HARD);
        src_req[`NVM_EXC_MEM] = i_memory_manage_fault_req;
        src_prio[`NVM_EXC_MEM] = sys_prio[0];
        src_req[`NVM_EXC_BUS] = i_bus_fault_req;
        src_prio[`NVM_EXC_BUS] = sys_prio[1];
        src_req[`NVM_EXC_USAGE] = i_usage_fault_req;
        src_prio[`NVM_EXC_USAGE] = sys_prio[2];
        src_req[`NVM_EXC_SVC] = i_supervisor_call_req;
        src_prio[`NVM_EXC_SVC] = sys_prio[3];
        src_req[`NVM_EXC_DBG] = i_debug_monitor_req;
        src_prio[`NVM_EXC_DBG] = sys_prio[4];
        src_req[`NVM_EXC_PSV] = i_pendable_service_req;
        src_prio[`NVM_EXC_PSV] = sys_prio[5];
        src_req[`NVM_EXC_TICK] = i_system_tick_timer;
        src_prio[`NVM_EXC_TICK] = sys_prio[6];
        for (int c = 0; c < NCHAN; c++) begin
            // Channels beyond the category count are absent
            src_req[16 + c] = chan_raw[c] & i_chan_enable[c]
                & (8'(c) < chan_count);
            src_prio[16 + c] = i_prio_override
                ? nvm_prio_t'({4'h0, i_chan_prio[c*`NVM_PRIO_BITS +: `NVM_PRIO_BITS]})
                : nvm_prio_t'(c + `NVM_CHAN_PRIO_OFS);
        end
    end

    // Pending latches: set by request, cleared on entry; set wins
    logic [NSRC-1:0] pend_r;
    logic [NSRC-1:0] active_r;
    logic [NSRC-1:0] clr_vec;
    logic entry_take;
    // Core takes the presented exception this cycle
    assign entry_take = i_entry_ack && o_exc_req;
    always_comb begin
        clr_vec = '0;
        if (entry_take) begin
            clr_vec[o_exc_num_full[IDXW-1:0]] = 1'b1;
        end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~clr_vec) | src_req;
        end
    end

    // Active source tracking for nesting
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            active_r <= '0;
        end else begin
            if (i_exit) begin
                // Entry in the same cycle as exit keeps its mark: set wins
                active_r <= clr_vec;
            end else begin
                active_r <= active_r | clr_vec;
            end
        end
    end

    // Priority tree of comparator stages
    logic tv [2*LVLS];
    nvm_prio_t tp [2*LVLS];
    logic [IDXW-1:0] ti [2*LVLS];
    genvar g;
    generate
        for (g = 0; g < LVLS; g++) begin : g_leaf
            assign tv[LVLS + g] = pend_r[g] & ~active_r[g];
            assign tp[LVLS + g] = src_prio[g];
            assign ti[LVLS + g] = IDXW'(g);
        end
        for (g = 1; g < LVLS; g++) begin : g_node
            nvm_prio_cmp #(.IDXW(IDXW)) u_cmp (
                .i_va(tv[2*g]),
                .i_pa(tp[2*g]),
                .i_ia(ti[2*g]),
                .i_vb(tv[2*g+1]),
                .i_pb(tp[2*g+1]),
                .i_ib(ti[2*g+1]),
                .o_v(tv[g]),
                .o_p(tp[g]),
                .o_i(ti[g])
            );
        end
    endgenerate

    // Winner must beat the running core priority to preempt
    logic win_ok;
    assign win_ok = tv[1] && (!i_core_prio_valid || (tp[1] < i_core_prio));

    // Registered request; replaced if stronger one arrives before entry
    logic exc_req_r;
    logic [IDXW-1:0] exc_idx_r;
    nvm_prio_t exc_prio_r;
    logic late_r;
    logic late_hit;
    // Stronger different source displaces one not yet entered
    assign late_hit = exc_req_r && (ti[1] != exc_idx_r) && (tp[1] < exc_prio_r);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            exc_req_r <= 1'b0;
            exc_idx_r <= '0;
            exc_prio_r <= '0;
            late_r <= 1'b0;
        end else begin
            late_r <= 1'b0;
            if (entry_take) begin
                exc_req_r <= 1'b0;
            end else if (win_ok) begin
                if (late_hit) begin
                    late_r <= 1'b1;
                end
                exc_req_r <= 1'b1;
                exc_idx_r <= ti[1];
                exc_prio_r <= tp[1];
            end else begin
                exc_req_r <= 1'b0;
            end
        end
    end

    // Vector address is four times the exception number
    logic [8:0] exc_num_w;
    assign exc_num_w = 9'(exc_idx_r);
    assign o_exc_req = exc_req_r;
    assign o_exc_num_full = exc_num_w;
    assign o_exc_num = exc_num_w[5:0];
    assign o_vector_addr = 32'({exc_num_w, 2'b00});
    assign o_exc_prio = exc_prio_r;
    assign o_late_arrival = late_r;

    // Fixed calibration value and channel count readback
    assign o_tick_calib = 24'(`NVM_TICK_CALIB);
    assign o_chan_count = chan_count;
endmodule

// ===== dv/nvm_irq_props.sv
`timescale 1ns/1ps
// Port checks of the vector controller
module nvm_irq_props
    import nvm_irq_pkg::*;
#(
    parameter nvm_cat_e CATEGORY = NVM_CAT2
) (
    // Clock, reset and core side
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_nmi_req,
    input wire logic i_core_prio_valid,
    input wire logic i_entry_ack,
    input wire logic i_exit,
    input wire logic i_prio_override,
    // Outputs watched
    input wire logic o_exc_req,
    input wire nvm_excnum_t o_exc_num,
    input wire logic [8:0] o_exc_num_full,
    input wire logic [31:0] o_vector_addr,
    input wire nvm_prio_t o_exc_prio,
    input wire logic o_late_arrival,
    input wire logic [23:0] o_tick_calib,
    input wire logic [7:0] o_chan_count
);
    // Channel count of the category
    localparam logic [8:0] NCAT = (CATEGORY <= NVM_CAT2) ? 9'h02d :
        (CATEGORY == NVM_CAT3) ? 9'h036 : 9'h039;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    chk_tick_calib: assert property (o_tick_calib == 24'h000fa0)
        else $error("tick calibration wrong");
    chk_chan_count: assert property (o_chan_count == NCAT[7:0])
        else $error("channel count wrong");
    chk_vec_num: assert property (o_exc_req |-> o_exc_num == o_exc_num_full[5:0] &&
        o_vector_addr == {21'h0, o_exc_num_full, 2'h0}) else $error("vector not num*4");
    chk_in_range: assert property (o_exc_req |-> o_exc_num_full < NCAT + 9'h010)
        else $error("exception beyond category");
    chk_no_reserved: assert property (o_exc_req |->
        !(o_exc_num inside {6'h00, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0d}))
        else $error("reserved slot requested");
    chk_nmi_wins: assert property (i_nmi_req && !i_core_prio_valid && !i_entry_ack &&
        !i_exit ##1 !i_entry_ack && !i_exit |=> o_exc_req && o_exc_num == 6'h02 &&
        o_exc_prio == 8'shfe) else $error("nmi not presented");
    chk_ack_drop: assert property (o_exc_req && i_entry_ack |=> !o_exc_req)
        else $error("request kept after entry");
    chk_req_holds: assert property (o_exc_req && !i_entry_ack |=> o_exc_req)
        else $error("request dropped before entry");
    chk_late_pulse: assert property (o_late_arrival |-> o_exc_req &&
        $past(o_exc_req) && o_exc_prio < $past(o_exc_prio)) else $error("bad late arrival");
    chk_default_prio: assert property (o_exc_req && !i_prio_override &&
        o_exc_num_full > 9'h00f |-> o_exc_prio == nvm_prio_t'(o_exc_num_full - 9'h009))
        else $error("channel default priority wrong");
endmodule

// ===== dv/nvm_core_model.sv
`timescale 1ns/1ps
// Core model: enters after a set delay, returns three cycles later
module nvm_core_model
    import nvm_irq_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Controller side
    input wire logic i_exc_req,
    input wire nvm_prio_t i_exc_prio,
    input wire logic [3:0] i_delay,
    output logic o_entry_ack,
    output logic o_exit,
    output logic o_prio_valid,
    output nvm_prio_t o_prio
);
    int wait_r;
    int run_r;
    // Ack only while a request stands; running priority held until exit
    always @(negedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_entry_ack <= 1'b0;
            o_exit <= 1'b0;
            o_prio_valid <= 1'b0;
            o_prio <= 8'sh00;
            wait_r <= 0;
            run_r <= 0;
        end else begin
            o_entry_ack <= 1'b0;
            o_exit <= 1'b0;
            if (run_r > 0) begin
                run_r <= run_r - 1;
                o_exit <= (run_r == 1);
                o_prio_valid <= (run_r != 1);
            end else if (i_exc_req) begin
                wait_r <= wait_r + 1;
                if (wait_r >= i_delay) begin
                    o_entry_ack <= 1'b1;
                    o_prio <= i_exc_prio;
                    o_prio_valid <= 1'b1;
                    wait_r <= 0;
                    run_r <= 3;
                end
            end
        end
    end
endmodule

// ===== dv/nested_irq_vector_map_tb_top.sv
`timescale 1ns/1ps
// Bench for the vector controller with a core model
module nested_irq_vector_map_tb_top;
    import nvm_irq_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [17:0] sb = '0;
    logic [6:0] dma = '0;
    logic [56:0] chan = '0;
    logic [56:0] en = '1;
    logic ovr = 1'b0;
    logic [227:0] cpri = '0;
    logic [27:0] spri = '0;
    logic [3:0] dly = 4'h0;
    logic ack, ext, pval, req, late;
    nvm_prio_t cprio, prio;
    nvm_excnum_t num;
    logic [8:0] numf;
    logic [31:0] vec;
    logic [23:0] calib;
    logic [7:0] ccnt;
    int err_total = 0;
    int n_compared = 0;
    // Rows: source, vector low byte, priority
    logic [23:0] rows [24] = '{24'h0008fe, 24'h0108fe, 24'h020cff, 24'h031000, 24'h041401,
        24'h051802, 24'h062c03, 24'h073004, 24'h083805, 24'h093c06, 24'h0a4408, 24'h0b4809,
        24'h0c4c0a, 24'h0d8c1a, 24'h0e901b, 24'h0f981d, 24'h10981d, 24'h11981d, 24'h126c12,
        24'h157815, 24'h188418, 24'h204007, 24'h38a01f, 24'h4cf033};
    always #2 i_clk = ~i_clk;
    nvm_irq_ctrl dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_nmi_req(sb[0]), .i_clock_security_failure(sb[1]),
        .i_hard_fault_req(sb[2]), .i_memory_manage_fault_req(sb[3]), .i_bus_fault_req(sb[4]),
        .i_usage_fault_req(sb[5]), .i_supervisor_call_req(sb[6]), .i_debug_monitor_req(sb[7]),
        .i_pendable_service_req(sb[8]), .i_system_tick_timer(sb[9]), .i_chan_req(chan),
        .i_supply_voltage_detector(sb[10]), .i_tamper_timestamp_request(sb[11]),
        .i_rtc_wakeup_request(sb[12]), .i_dma_chan_req(dma),
        .i_usb_high_priority_request(sb[13]), .i_usb_low_priority_request(sb[14]),
        .i_comp_external_event_line(sb[16:15]), .i_touch_sense_request(sb[17]),
        .i_chan_enable(en), .i_prio_override(ovr), .i_chan_prio(cpri), .i_sys_prio(spri),
        .i_core_prio_valid(pval), .i_core_prio(cprio), .i_entry_ack(ack), .i_exit(ext),
        .o_exc_req(req), .o_exc_num(num), .o_exc_num_full(numf), .o_vector_addr(vec),
        .o_exc_prio(prio), .o_late_arrival(late), .o_tick_calib(calib), .o_chan_count(ccnt));
    nvm_core_model u_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_exc_req(req), .i_exc_prio(prio),
        .i_delay(dly), .o_entry_ack(ack), .o_exit(ext), .o_prio_valid(pval), .o_prio(cprio));
    // Verdict and end of run
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One source line by index
    task automatic drive(input int s, input logic v);
        if (s < 18) sb[s] = v;
        else if (s < 25) dma[s-18] = v;
        else chan[s-32] = v;
    endtask
    task automatic wait_req(input logic lvl);
        for (int k = 0; k < 24 && req !== lvl; k++) @(negedge i_clk);
        chk("wait_req", {31'h0, req}, {31'h0, lvl});
        if (req !== lvl) stop_test();
    endtask
    // Main sequence
    initial begin
        repeat (4) @(negedge i_clk);
        chk("rst", vec | {31'h0, req} | {31'h0, late} | {24'h0, prio}, 32'h0);
        chk("calib", {8'h0, calib}, 32'h0000_0fa0);
        chk("count", {24'h0, ccnt}, 32'h0000_002d);
        i_rstn = 1'b1;
        for (int r = 0; r < 24; r++) begin
            dly = 4'(r % 3);
            @(negedge i_clk);
            drive(int'(rows[r][23:16]), 1'b1);
            wait_req(1'b1);
            chk("num", {26'h0, num}, {26'h0, rows[r][15:10]});
            chk("vec", vec, {24'h0, rows[r][15:8]});
            chk("prio", {24'h0, prio}, {24'h0, rows[r][7:0]});
            drive(int'(rows[r][23:16]), 1'b0);
            wait_req(1'b0);
            repeat (5) @(negedge i_clk);
        end
        en[0] = 1'b0;
        chan[0] = 1'b1;
        chan[45] = 1'b1;
        repeat (6) @(negedge i_clk);
        chk("refuse", {31'h0, req}, 32'h0);
        chan = '0;
        en = '1;
        dly = 4'h8;
        sb[14] = 1'b1;
        wait_req(1'b1);
        dma[0] = 1'b1;
        for (int k = 0; k < 6 && num !== 6'h1b; k++) @(negedge i_clk);
        chk("late_num", {26'h0, num}, 32'h0000_001b);
        chk("late", {31'h0, late}, 32'h1);
        sb = '0;
        dma = '0;
        wait_req(1'b0);
        wait_req(1'b1);
        chk("resume", {26'h0, num}, 32'h0000_0024);
        wait_req(1'b0);
        dly = 4'h2;
        ovr = 1'b1;
        cpri[83:80] = 4'h1;
        cpri[47:44] = 4'hf;
        spri[27:24] = 4'h2;
        repeat (2) @(negedge i_clk);
        sb[14] = 1'b1;
        sb[9] = 1'b1;
        dma[0] = 1'b1;
        wait_req(1'b1);
        chk("ovr_num", {26'h0, num}, 32'h0000_0024);
        chk("ovr_prio", {24'h0, prio}, 32'h0000_0001);
        sb = '0;
        dma = '0;
        repeat (60) @(negedge i_clk);
        sb[4:3] = 2'h3;
        wait_req(1'b1);
        chk("tie", {26'h0, num}, 32'h0000_0004);
        sb = '0;
        repeat (60) @(negedge i_clk);
        ovr = 1'b0;
        repeat (4) @(negedge i_clk);
        stop_test();
    end
endmodule
bind nvm_irq_ctrl nvm_irq_props #(.CATEGORY(CATEGORY)) u_props (.*);
